// ==== src/umdm_consts.svh ====
// How it works
// - Send-request pin active low, software drivable
// - Send-request pin doubles as half-duplex direction
// - Clear-to-send low-active, readable, gates auto flow
// - Terminal-ready pin active low, software driven
// - Status inputs readable; only clear-to-send touches data path, by gating transmit
// - Multi-function pin shows one selected function
// - General output low while modem bit set
// - Modem control bits clear at reset
// - Baud function drives the sixteen-times clock
// - Receive-ready function gives low-active indication
// - Clock from oscillator input, copy driven out
// - Direction pin high receive, low transmit
`ifndef UMDM_CONSTS_SVH
`define UMDM_CONSTS_SVH

`define UMDM_REG_W 8
`define UMDM_REG_RESET 8'h00
// Modem control fields
`define UMDM_MCR_DTR 0
`define UMDM_MCR_RTS 1
`define UMDM_MCR_OP2 3
// Enhanced feature fields
`define UMDM_EFR_AUTO_RTS 6
`define UMDM_EFR_AUTO_CTS 7
// Feature control field
`define UMDM_FEATURE_CONTROL_REG_RS485 3
// Alternate function select field
`define UMDM_AFR_SEL_LSB 1
`define UMDM_AFR_SEL_MSB 2
`define UMDM_AFR_SEL_OP2 2'h0
`define UMDM_AFR_SEL_BAUD 2'h1
`define UMDM_AFR_SEL_RXRDY 2'h2
// Pin levels
`define UMDM_PIN_IDLE 1'b1
`define UMDM_PIN_ACTIVE 1'b0
`define UMDM_IN_PINS 4
`define UMDM_SYNC_RESET 4'hf

`endif

// ==== src/umdm_pkg.sv ====
`default_nettype none
package umdm_pkg;

  typedef enum logic [1:0] {
    MF_GPO,
    MF_BAUD,
    MF_RXRDY
  } umdm_mf_e;

  typedef enum logic {
    DIR_RX,
    DIR_TX
  } umdm_dir_e;

  // Active-high views of the low-active modem inputs
  typedef struct packed {
    logic ring;
    logic carrier;
    logic set_ready;
    logic clear_to_send;
  } umdm_status_s;

  typedef struct packed {
    logic req_to_send_n;
    logic terminal_ready_n;
    logic multi_function_n;
  } umdm_pins_s;

endpackage
`default_nettype wire

// ==== src/umdm_pin_sync.sv ====
`default_nettype none
module umdm_pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins and synchronised copy
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_width_check
    $error("umdm_pin_sync needs at least one pin");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        meta_q[i] <= RESET_VAL[i];
        sync_q[i] <= RESET_VAL[i];
      end else begin
        meta_q[i] <= pin_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire

// ==== src/umdm_modem_pins.sv ====
`include "umdm_consts.svh"
`default_nettype none
module umdm_modem_pins #(
  parameter int REG_W = `UMDM_REG_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Oscillator copy
  output logic osc_clock_out,
  // Register writes from the host port
  input wire logic mcr_wr,
  input wire logic efr_wr,
  input wire logic feature_control_reg_wr,
  input wire logic afr_wr,
  input wire logic [REG_W-1:0] reg_wdata,
  // Register readback
  output logic [REG_W-1:0] mcr_rdata,
  output logic [REG_W-1:0] efr_rdata,
  output logic [REG_W-1:0] feature_control_reg_rdata,
  output logic [REG_W-1:0] afr_rdata,
  // Modem inputs
  input wire logic clear_to_send_in_n,
  input wire logic set_ready_in_n,
  input wire logic carrier_detect_in_n,
  input wire logic ring_indicator_in_n,
  // Modem outputs
  output logic req_to_send_out_n,
  output logic terminal_ready_out_n,
  output logic multi_function_out_n,
  // Channel core side
  input wire logic baud16_in,
  input wire logic rx_ready_in,
  input wire logic rx_flow_halt_in,
  input wire logic tx_byte_load_in,
  input wire logic tx_done_in,
  output logic tx_allow_out,
  output umdm_pkg::umdm_status_s modem_status_out
);

  // Refused at elaboration: the highest field must fit in the register
  if (REG_W <= `UMDM_EFR_AUTO_CTS) begin : g_width_check
    $error("umdm_modem_pins register width too small");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Oscillator buffer: a flop cannot copy its own clock, so this one is a wire

  assign osc_clock_out = clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [REG_W-1:0] mcr_q, mcr_d;
  logic [REG_W-1:0] efr_q, efr_d;
  logic [REG_W-1:0] feature_control_reg_q, feature_control_reg_d;
  logic [REG_W-1:0] afr_q, afr_d;

  always_comb begin
    mcr_d = mcr_q;
    efr_d = efr_q;
    feature_control_reg_d = feature_control_reg_q;
    afr_d = afr_q;
    if (mcr_wr) begin
      mcr_d = reg_wdata;
    end
    if (efr_wr) begin
      efr_d = reg_wdata;
    end
    if (feature_control_reg_wr) begin
      feature_control_reg_d = reg_wdata;
    end
    if (afr_wr) begin
      afr_d = reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcr_q <= REG_W'(`UMDM_REG_RESET);
      efr_q <= REG_W'(`UMDM_REG_RESET);
      feature_control_reg_q <= REG_W'(`UMDM_REG_RESET);
      afr_q <= REG_W'(`UMDM_REG_RESET);
    end else begin
      mcr_q <= mcr_d;
      efr_q <= efr_d;
      feature_control_reg_q <= feature_control_reg_d;
      afr_q <= afr_d;
    end
  end

  assign mcr_rdata = mcr_q;
  assign efr_rdata = efr_q;
  assign feature_control_reg_rdata = feature_control_reg_q;
  assign afr_rdata = afr_q;

  logic sw_rts, sw_dtr, sw_op2, auto_rts_en, auto_cts_en, rs485_en;
  logic [1:0] afr_sel;

  assign sw_rts = mcr_q[`UMDM_MCR_RTS];
  assign sw_dtr = mcr_q[`UMDM_MCR_DTR];
  assign sw_op2 = mcr_q[`UMDM_MCR_OP2];
  assign auto_rts_en = efr_q[`UMDM_EFR_AUTO_RTS];
  assign auto_cts_en = efr_q[`UMDM_EFR_AUTO_CTS];
  assign rs485_en = feature_control_reg_q[`UMDM_FEATURE_CONTROL_REG_RS485];
  assign afr_sel = afr_q[`UMDM_AFR_SEL_MSB:`UMDM_AFR_SEL_LSB];

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [`UMDM_IN_PINS-1:0] pins_raw, pins_sync;

  assign pins_raw = {ring_indicator_in_n, carrier_detect_in_n,
                     set_ready_in_n, clear_to_send_in_n};

  umdm_pin_sync #(
    .WIDTH(`UMDM_IN_PINS),
    .RESET_VAL(`UMDM_SYNC_RESET)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(pins_raw),
    .sync_out(pins_sync)
  );

  umdm_pkg::umdm_status_s status_now;

  // Low-active pins read as active-high status
  assign status_now = umdm_pkg::umdm_status_s'(~pins_sync);

  ////////////////////////////////////////////////////////////////////////////////
  // Half-duplex direction state

  umdm_pkg::umdm_dir_e dir_q, dir_d;

  always_comb begin
    dir_d = dir_q;
    unique case (dir_q)
      umdm_pkg::DIR_RX: begin
        if (tx_byte_load_in) begin
          dir_d = umdm_pkg::DIR_TX;
        end
      end
      umdm_pkg::DIR_TX: begin
        // A new byte in the same cycle keeps the line turned to transmit
        if (tx_done_in && !tx_byte_load_in) begin
          dir_d = umdm_pkg::DIR_RX;
        end
      end
    endcase
    if (!rs485_en) begin
      dir_d = umdm_pkg::DIR_RX;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_q <= umdm_pkg::DIR_RX;
    end else begin
      dir_q <= dir_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Multi-function select; the unused code falls back to general output

  umdm_pkg::umdm_mf_e mf_mode;

  always_comb begin
    unique case (afr_sel)
      `UMDM_AFR_SEL_BAUD: mf_mode = umdm_pkg::MF_BAUD;
      `UMDM_AFR_SEL_RXRDY: mf_mode = umdm_pkg::MF_RXRDY;
      default: mf_mode = umdm_pkg::MF_GPO;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output pins and core handshakes

  umdm_pkg::umdm_pins_s pins_q, pins_d;
  umdm_pkg::umdm_status_s status_q, status_d;
  logic tx_allow_q, tx_allow_d;

  always_comb begin
    pins_d = pins_q;
    // Auto mode only takes over once software has asserted the pin
    if (rs485_en) begin
      pins_d.req_to_send_n = (dir_q == umdm_pkg::DIR_TX) ?
                             `UMDM_PIN_ACTIVE : `UMDM_PIN_IDLE;
    end else if (auto_rts_en && sw_rts) begin
      pins_d.req_to_send_n = rx_flow_halt_in ?
                             `UMDM_PIN_IDLE : `UMDM_PIN_ACTIVE;
    end else begin
      pins_d.req_to_send_n = ~sw_rts;
    end
    pins_d.terminal_ready_n = ~sw_dtr;
    unique case (mf_mode)
      umdm_pkg::MF_GPO: pins_d.multi_function_n = ~sw_op2;
      umdm_pkg::MF_BAUD: pins_d.multi_function_n = baud16_in;
      umdm_pkg::MF_RXRDY: pins_d.multi_function_n = ~rx_ready_in;
    endcase
    status_d = status_now;
    tx_allow_d = !auto_cts_en || status_now.clear_to_send;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pins_q <= '{`UMDM_PIN_IDLE, `UMDM_PIN_IDLE, `UMDM_PIN_IDLE};
      status_q <= '0;
      tx_allow_q <= 1'b1;
    end else begin
      pins_q <= pins_d;
      status_q <= status_d;
      tx_allow_q <= tx_allow_d;
    end
  end

  assign req_to_send_out_n = pins_q.req_to_send_n;
  assign terminal_ready_out_n = pins_q.terminal_ready_n;
  assign multi_function_out_n = pins_q.multi_function_n;
  assign tx_allow_out = tx_allow_q;
  assign modem_status_out = status_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sw_rts_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(rs485_en) && !$past(auto_rts_en)
    |-> req_to_send_out_n == !$past(sw_rts))
    else $error("send-request pin does not follow software bit");

  auto_rts_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(rs485_en) && $past(auto_rts_en) && $past(sw_rts)
    |-> req_to_send_out_n == $past(rx_flow_halt_in))
    else $error("auto send-request does not track receiver halt");

  dir_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(rs485_en)
    |-> req_to_send_out_n == ($past(dir_q) == umdm_pkg::DIR_RX))
    else $error("direction pin level wrong for line state");

  dir_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    rs485_en && feature_control_reg_q == $past(feature_control_reg_q) && tx_byte_load_in ##1 rs485_en
    |-> ##1 !req_to_send_out_n)
    else $error("byte load did not turn line to transmit");

  cts_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst, 3) && !$past(sys_rst) && $past(auto_cts_en)
    |-> tx_allow_out == !$past(clear_to_send_in_n, 3))
    else $error("clear-to-send gate wrong");

  dtr_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) |-> terminal_ready_out_n == !$past(mcr_q[`UMDM_MCR_DTR]))
    else $error("terminal-ready pin does not follow software bit");

  status_view_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst, 3) && !$past(sys_rst)
    |-> modem_status_out.ring == !$past(ring_indicator_in_n, 3)
        && modem_status_out.carrier == !$past(carrier_detect_in_n, 3)
        && modem_status_out.set_ready == !$past(set_ready_in_n, 3)
        && modem_status_out.clear_to_send == !$past(clear_to_send_in_n, 3))
    else $error("modem status does not reflect pins");

  op2_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(afr_sel) == `UMDM_AFR_SEL_OP2
    |-> multi_function_out_n == !$past(sw_op2))
    else $error("general output level wrong");

  mcr_reset_a: assert property (@(posedge clk)
    $past(sys_rst) |-> mcr_q == REG_W'(`UMDM_REG_RESET) && multi_function_out_n)
    else $error("modem control not cleared by reset");

  baud_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(afr_sel) == `UMDM_AFR_SEL_BAUD
    |-> multi_function_out_n == $past(baud16_in))
    else $error("baud clock not on multi-function pin");

  rxrdy_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && $past(afr_sel) == `UMDM_AFR_SEL_RXRDY
    |-> multi_function_out_n == !$past(rx_ready_in))
    else $error("receive-ready indication wrong");

  // Software bit off must win over the automatic request
  rts_refused_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(rs485_en) && !$past(sw_rts)
    |-> req_to_send_out_n)
    else $error("send-request pin asserted without software bit");

  dir_done_a: assert property (@(posedge clk) disable iff (sys_rst)
    rs485_en && tx_done_in && !tx_byte_load_in ##1 rs485_en
    |-> ##1 req_to_send_out_n)
    else $error("line not turned to receive after last stop bit");

  dir_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(rs485_en) |-> dir_q == umdm_pkg::DIR_RX)
    else $error("direction state not in receive while mode is off");

  tx_free_a: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(sys_rst) && !$past(auto_cts_en) |-> tx_allow_out)
    else $error("transmit blocked while clear-to-send gating is off");

endmodule
`default_nettype wire

// ==== tb/umdm_modem_model.sv ====
`default_nettype none
module umdm_modem_model (
  // Clock
  input wire logic clk,
  // Lines toward the channel
  output logic clear_to_send_in_n,
  output logic set_ready_in_n,
  output logic carrier_detect_in_n,
  output logic ring_indicator_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Unused modem lines are tied high, so idle is all ones
  initial begin
    {ring_indicator_in_n, carrier_detect_in_n, set_ready_in_n, clear_to_send_in_n} = 4'hf;
  end
  // Order ring, carrier, set-ready, clear-to-send; low is asserted
  task automatic drive(input logic [3:0] lv_n);
    @(negedge clk);
    {ring_indicator_in_n, carrier_detect_in_n, set_ready_in_n, clear_to_send_in_n} = lv_n;
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic mcr_wr = 1'b0, efr_wr = 1'b0, feature_control_reg_wr = 1'b0, afr_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] mcr_rdata, efr_rdata, feature_control_reg_rdata, afr_rdata;
  logic clear_to_send_in_n, set_ready_in_n, carrier_detect_in_n, ring_indicator_in_n;
  logic req_to_send_out_n, terminal_ready_out_n, multi_function_out_n, osc_clock_out;
  logic baud16_in = 1'b0, rx_ready_in = 1'b0, rx_flow_halt_in = 1'b0;
  logic tx_byte_load_in = 1'b0, tx_done_in = 1'b0, tx_allow_out;
  umdm_pkg::umdm_status_s modem_status_out;
  logic [7:0] sw [5] = '{8'h01, 8'h02, 8'h08, 8'h0b, 8'h00};
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  umdm_modem_pins #(.REG_W(8)) DUT (
    .clk(clk), .sys_rst(sys_rst), .osc_clock_out(osc_clock_out),
    .mcr_wr(mcr_wr), .efr_wr(efr_wr), .feature_control_reg_wr(feature_control_reg_wr), .afr_wr(afr_wr),
    .reg_wdata(reg_wdata), .mcr_rdata(mcr_rdata), .efr_rdata(efr_rdata),
    .feature_control_reg_rdata(feature_control_reg_rdata), .afr_rdata(afr_rdata),
    .clear_to_send_in_n(clear_to_send_in_n), .set_ready_in_n(set_ready_in_n),
    .carrier_detect_in_n(carrier_detect_in_n), .ring_indicator_in_n(ring_indicator_in_n),
    .req_to_send_out_n(req_to_send_out_n), .terminal_ready_out_n(terminal_ready_out_n),
    .multi_function_out_n(multi_function_out_n), .baud16_in(baud16_in),
    .rx_ready_in(rx_ready_in), .rx_flow_halt_in(rx_flow_halt_in),
    .tx_byte_load_in(tx_byte_load_in), .tx_done_in(tx_done_in),
    .tx_allow_out(tx_allow_out), .modem_status_out(modem_status_out)
  );

  umdm_modem_model modem (
    .clk(clk), .clear_to_send_in_n(clear_to_send_in_n), .set_ready_in_n(set_ready_in_n),
    .carrier_detect_in_n(carrier_detect_in_n), .ring_indicator_in_n(ring_indicator_in_n)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Sel 0 modem, 1 enhanced, 2 feature, 3 alternate; ends after pin update
  task automatic wr(input int sel, input logic [7:0] d);
    @(negedge clk);
    reg_wdata = d;
    {afr_wr, feature_control_reg_wr, efr_wr, mcr_wr} = 4'h1 << sel;
    @(negedge clk);
    {afr_wr, feature_control_reg_wr, efr_wr, mcr_wr} = 4'h0;
    @(negedge clk);
  endtask

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Whole run needs well under 300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk({req_to_send_out_n, terminal_ready_out_n, multi_function_out_n}, 8'h07);
    chk(mcr_rdata | efr_rdata | feature_control_reg_rdata | afr_rdata, 8'h00);
    chk({4'h0, modem_status_out}, 8'h00);
    chk(tx_allow_out, 8'h01);
    chk(osc_clock_out, 8'h00);
    #60 chk(osc_clock_out, 8'h01);
    foreach (sw[i]) begin
      wr(0, sw[i]);
      chk(mcr_rdata, sw[i]);
      chk({req_to_send_out_n, terminal_ready_out_n, multi_function_out_n},
          {5'h00, ~sw[i][1], ~sw[i][0], ~sw[i][3]});
    end
    // Reserved select code falls back to the general output
    wr(0, 8'h08);
    wr(3, 8'h06);
    chk(afr_rdata, 8'h06);
    chk(multi_function_out_n, 8'h00);
    wr(3, 8'h02);
    for (int i = 0; i < 4; i++) begin
      baud16_in = i[0];
      @(negedge clk);
      chk(multi_function_out_n, {7'h00, i[0]});
    end
    wr(3, 8'h04);
    for (int i = 0; i < 2; i++) begin
      rx_ready_in = ~i[0];
      @(negedge clk);
      chk(multi_function_out_n, {7'h00, i[0]});
    end
    // Send-request asserted before the automatic mode is switched on
    wr(0, 8'h02);
    wr(1, 8'h40);
    chk(efr_rdata, 8'h40);
    for (int i = 0; i < 2; i++) begin
      rx_flow_halt_in = ~i[0];
      @(negedge clk);
      chk(req_to_send_out_n, {7'h00, ~i[0]});
    end
    // Automatic mode has no effect while software holds the request off
    wr(0, 8'h00);
    chk(req_to_send_out_n, 8'h01);
    wr(0, 8'h02);
    wr(1, 8'h80);
    modem.drive(4'hf);
    repeat (4) @(negedge clk);
    chk(tx_allow_out, 8'h00);
    modem.drive(4'he);
    repeat (4) @(negedge clk);
    chk({3'h0, tx_allow_out, modem_status_out}, 8'h11);
    modem.drive(4'h1);
    repeat (4) @(negedge clk);
    chk({3'h0, tx_allow_out, modem_status_out}, 8'h0e);
    chk(req_to_send_out_n, 8'h00);
    // Direction mode overrides the software request
    wr(2, 8'h08);
    chk(feature_control_reg_rdata, 8'h08);
    @(negedge clk);
    chk(req_to_send_out_n, 8'h01);
    tx_byte_load_in = 1'b1;
    @(negedge clk);
    tx_byte_load_in = 1'b0;
    repeat (2) @(negedge clk);
    chk(req_to_send_out_n, 8'h00);
    // A new byte in the finishing cycle keeps the line at transmit
    tx_byte_load_in = 1'b1;
    tx_done_in = 1'b1;
    @(negedge clk);
    tx_byte_load_in = 1'b0;
    tx_done_in = 1'b0;
    repeat (2) @(negedge clk);
    chk(req_to_send_out_n, 8'h00);
    tx_done_in = 1'b1;
    @(negedge clk);
    tx_done_in = 1'b0;
    repeat (2) @(negedge clk);
    chk(req_to_send_out_n, 8'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
